// ### hdl/frame_sync_map.svh
`ifndef FRAME_SYNC_MAP_SVH
`define FRAME_SYNC_MAP_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define DEFECT_STATUS_ADDR 16'h1107
`define INT_STATUS_ADDR 16'h110B
`define INT_MASK_ADDR 16'h110F

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SEVERE_BIT 1
`define LOSS_BIT 2
`define INT_STATUS_RST 8'h00
`define INT_MASK_RST 8'h06
`define RD_IDLE 8'h00

// ****************************************************************
// Frame counts and timing.
// ****************************************************************
`define SEVERE_DECLARE_FRAMES 4'h4
`define SEVERE_CLEAR_FRAMES 4'h2
`define INSYNC_FRAMES_DEF 4'h8
`define SEVERE_PERSIST_NS 3000000
`define CLK_PERIOD_NS 4
`define SEVERE_PERSIST_CYC \
  ((`SEVERE_PERSIST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hdl/frame_sync_pkg.sv
package frame_sync_pkg;

  typedef enum logic [3:0] {
    ST_IN_FRAME = 4'h1,
    ST_SEVERE = 4'h2,
    ST_SEVERE_LOSS = 4'h4,
    ST_LOSS = 4'h8
  } align_state_e;

  // One framing verdict per received frame.
  typedef struct packed {
    logic strobe;
    logic err;
  } frame_obs_s;

  typedef struct packed {
    align_state_e state;
    logic severely_errored_frame_defect;
    logic frame_loss_defect;
    logic [7:0] int_stat;
    logic [7:0] int_mask;
    logic [7:0] rd_data;
    logic irq_n;
  } monitor_state_s;

endpackage

// ### hdl/consec_counter.sv
`timescale 1ns/100ps
// ****************************************************************
// Run length of consecutive qualifying frames.
// ****************************************************************
module consec_counter #(
  parameter int unsigned W = 4
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic step_i,
  input wire logic hit_i,
  input wire logic restart_i,
  output logic [W-1:0] count_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } run_state_s;

  run_state_s st_r;
  run_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (restart_i) begin
      st_nxt.cnt = '0;
    end else if (step_i) begin
      if (!hit_i) begin
        st_nxt.cnt = '0;
      end else if (st_r.cnt != {W{1'b1}}) begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_o = st_r.cnt;

endmodule

// ### hdl/persist_timer.sv
`timescale 1ns/100ps
// ****************************************************************
// Persistence timer: expires after CYCLES cycles of run.
// ****************************************************************
module persist_timer #(
  parameter int unsigned CYCLES = 750000,
  parameter int unsigned W = 20
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  output logic expired_o
);

  localparam logic [W-1:0] LIMIT = W'(CYCLES);

  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_s;

  timer_state_s st_r;
  timer_state_s st_nxt;

  // The count saturates so a long stay never wraps back below the limit.
  always_comb begin
    st_nxt = st_r;
    if (!run_i) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt < LIMIT) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired_o = run_i && (st_r.cnt >= LIMIT);

endmodule

// ### hdl/frame_sync_monitor.sv
`timescale 1ns/100ps
`include "frame_sync_map.svh"
// Notes on behaviour
// - In-frame: check every frame, tolerate isolated errors.
// - Four consecutive errored frames declare severe defect.
// - Severe defect shows in status bit 1.
// - Severe defect change sets interrupt bit 1, irq.
// - Two clean frames clear severe, back in-frame.
// - Errored frames keep severe defect declared.
// - Severe held 3 ms declares frame loss.
// - Frame loss shows in status bit 2.
module frame_sync_monitor
  import frame_sync_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = `SEVERE_PERSIST_CYC,
  parameter int unsigned PERSIST_W = 20,
  parameter logic [3:0] INSYNC_FRAMES = `INSYNC_FRAMES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire frame_obs_s frame_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  output logic irq_n_o,
  output logic severely_errored_frame_defect_o,
  output logic frame_loss_defect_o
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [3:0] run_len(input logic [3:0] cnt,
                                         input logic hit);
    logic [3:0] r;
    r = 4'h0;
    if (hit) begin
      r = (cnt == 4'hF) ? cnt : cnt + 4'h1;
    end
    return r;
  endfunction

  function automatic logic [7:0] defect_byte(input monitor_state_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`SEVERE_BIT] = s.severely_errored_frame_defect;
    b[`LOSS_BIT] = s.frame_loss_defect;
    return b;
  endfunction

  monitor_state_s st_r;
  monitor_state_s st_nxt;
  logic [3:0] err_cnt;
  logic [3:0] good_cnt;
  logic [3:0] err_run;
  logic [3:0] good_run;
  logic [7:0] clr;
  logic [7:0] ev;
  logic restart;
  logic persist_expired;
  logic persist_run;

  // ****************************************************************
  // Frame run counters and persistence timer.
  // ****************************************************************
  // Runs restart on every state change so each state judges only
  // the frames seen since it was entered.
  assign restart = (st_nxt.state != st_r.state);
  assign persist_run = (st_r.state == ST_SEVERE);

  consec_counter #(.W(4)) u_err_run (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .step_i(frame_i.strobe),
    .hit_i(frame_i.err),
    .restart_i(restart),
    .count_o(err_cnt)
  );

  consec_counter #(.W(4)) u_good_run (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .step_i(frame_i.strobe),
    .hit_i(!frame_i.err),
    .restart_i(restart),
    .count_o(good_cnt)
  );

  persist_timer #(.CYCLES(PERSIST_CYCLES), .W(PERSIST_W)) u_persist (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(persist_run),
    .expired_o(persist_expired)
  );

  // ****************************************************************
  // Alignment state machine and register file.
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    err_run = run_len(err_cnt, frame_i.err);
    good_run = run_len(good_cnt, !frame_i.err);
    case (st_r.state)
      ST_IN_FRAME: begin
        // Isolated errors only grow the run; the run resets on a clean
        // frame, so the state is left only on four in a row.
        if (frame_i.strobe && err_run >= `SEVERE_DECLARE_FRAMES) begin
          st_nxt.state = ST_SEVERE;
          st_nxt.severely_errored_frame_defect = 1'b1;
        end
      end
      ST_SEVERE: begin
        // Expiry takes precedence over a clean pair in the same cycle,
        // since the defect has then persisted for the full time.
        if (persist_expired) begin
          st_nxt.state = ST_SEVERE_LOSS;
          st_nxt.frame_loss_defect = 1'b1;
        end else if (frame_i.strobe &&
                     good_run >= `SEVERE_CLEAR_FRAMES) begin
          st_nxt.state = ST_IN_FRAME;
          st_nxt.severely_errored_frame_defect = 1'b0;
        end
        // Errored frames leave the defect declared.
      end
      ST_SEVERE_LOSS: begin
        if (frame_i.strobe && good_run >= `SEVERE_CLEAR_FRAMES) begin
          st_nxt.state = ST_LOSS;
          st_nxt.severely_errored_frame_defect = 1'b0;
        end
      end
      ST_LOSS: begin
        if (frame_i.strobe && err_run >= `SEVERE_DECLARE_FRAMES) begin
          st_nxt.state = ST_SEVERE_LOSS;
          st_nxt.severely_errored_frame_defect = 1'b1;
        end else if (frame_i.strobe && good_run >= INSYNC_FRAMES) begin
          st_nxt.state = ST_IN_FRAME;
          st_nxt.frame_loss_defect = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ST_IN_FRAME;
        st_nxt.severely_errored_frame_defect = 1'b0;
        st_nxt.frame_loss_defect = 1'b0;
      end
    endcase

    ev = 8'h00;
    ev[`SEVERE_BIT] = st_nxt.severely_errored_frame_defect !=
                      st_r.severely_errored_frame_defect;
    ev[`LOSS_BIT] = st_nxt.frame_loss_defect != st_r.frame_loss_defect;

    // Read clears all bits; a write of one clears that bit too.
    clr = 8'h00;
    if (rd_i && addr_i == `INT_STATUS_ADDR) begin
      clr = 8'hFF;
    end else if (wr_i && addr_i == `INT_STATUS_ADDR) begin
      clr = wdata_i;
    end
    // A new event in the clearing cycle survives the clear.
    st_nxt.int_stat = (st_r.int_stat & ~clr) | ev;

    if (wr_i && addr_i == `INT_MASK_ADDR) begin
      st_nxt.int_mask = wdata_i;
    end

    st_nxt.rd_data = `RD_IDLE;
    if (rd_i) begin
      case (addr_i)
        `DEFECT_STATUS_ADDR: st_nxt.rd_data = defect_byte(st_r);
        `INT_STATUS_ADDR: st_nxt.rd_data = st_r.int_stat;
        `INT_MASK_ADDR: st_nxt.rd_data = st_r.int_mask;
        default: st_nxt.rd_data = `RD_IDLE;
      endcase
    end

    st_nxt.irq_n = ~|(st_nxt.int_stat & st_nxt.int_mask);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r.state <= ST_IN_FRAME;
      st_r.severely_errored_frame_defect <= 1'b0;
      st_r.frame_loss_defect <= 1'b0;
      st_r.int_stat <= `INT_STATUS_RST;
      st_r.int_mask <= `INT_MASK_RST;
      st_r.rd_data <= `RD_IDLE;
      st_r.irq_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o = st_r.rd_data;
  assign irq_n_o = st_r.irq_n;
  assign severely_errored_frame_defect_o =
    st_r.severely_errored_frame_defect;
  assign frame_loss_defect_o = st_r.frame_loss_defect;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_bad_frame;
    frame_i.strobe && frame_i.err;
  endsequence

  sequence s_good_frame;
    frame_i.strobe && !frame_i.err;
  endsequence

  sequence s_fourth_bad;
    st_r.state == ST_IN_FRAME && err_cnt == 4'h3 ##0 s_bad_frame;
  endsequence

  sequence s_second_good;
    st_r.state == ST_SEVERE && good_cnt == 4'h1 && !persist_expired
      ##0 s_good_frame;
  endsequence

  sequence s_status_read;
    rd_i && addr_i == `DEFECT_STATUS_ADDR;
  endsequence

  a_isolated_err_tolerated: assert property (
    (st_r.state == ST_IN_FRAME && err_cnt < 4'h3) ##0 s_bad_frame
      |=> st_r.state == ST_IN_FRAME &&
          !st_r.severely_errored_frame_defect)
    else $error("In-frame left before four errored frames.");

  a_severe_declare: assert property (
    s_fourth_bad |=> st_r.state == ST_SEVERE &&
      st_r.severely_errored_frame_defect && !st_r.frame_loss_defect)
    else $error("Severe defect not declared on fourth bad frame.");

  a_status_severe_bit: assert property (
    s_status_read |=> rd_data_o[`SEVERE_BIT] ==
      $past(st_r.severely_errored_frame_defect))
    else $error("Status bit 1 does not show the severe defect.");

  a_change_irq_set: assert property (
    $changed(st_r.severely_errored_frame_defect) |->
      st_r.int_stat[`SEVERE_BIT] &&
      (!st_r.int_mask[`SEVERE_BIT] || !irq_n_o))
    else $error("Severe defect change not flagged in interrupt.");

  a_severe_clear: assert property (
    s_second_good |=> st_r.state == ST_IN_FRAME &&
      !st_r.severely_errored_frame_defect ##1
      st_r.state == ST_IN_FRAME)
    else $error("Two clean frames did not clear the severe defect.");

  a_severe_hold: assert property (
    (st_r.state == ST_SEVERE && !persist_expired) ##0 s_bad_frame
      |=> st_r.severely_errored_frame_defect)
    else $error("Severe defect dropped while errors continue.");

  a_loss_declare: assert property (
    (st_r.state == ST_SEVERE && persist_expired) |=>
      st_r.state == ST_SEVERE_LOSS && st_r.frame_loss_defect &&
      st_r.severely_errored_frame_defect)
    else $error("Frame loss not declared after persistence.");

  a_loss_early: assert property (
    $rose(st_r.frame_loss_defect) |->
      $past(st_r.state) == ST_SEVERE)
    else $error("Frame loss declared without severe persistence.");

  a_status_loss_bit: assert property (
    s_status_read |=> rd_data_o[`LOSS_BIT] ==
      $past(st_r.frame_loss_defect))
    else $error("Status bit 2 does not show the frame loss defect.");

  a_read_clears: assert property (
    (rd_i && addr_i == `INT_STATUS_ADDR && ev == 8'h00) |=>
      st_r.int_stat == 8'h00 && irq_n_o)
    else $error("Interrupt status read did not clear and release.");

  sequence s_loss_change;
    $changed(st_r.frame_loss_defect);
  endsequence

  a_loss_change_irq: assert property (
    s_loss_change |-> st_r.int_stat[`LOSS_BIT] &&
      (!st_r.int_mask[`LOSS_BIT] || !irq_n_o))
    else $error("Frame loss change not flagged in interrupt.");

  a_loss_after_timer: assert property (
    $rose(st_r.frame_loss_defect) |-> $past(persist_expired))
    else $error("Frame loss declared before the persistence time.");

  a_loss_clear_path: assert property (
    $fell(st_r.frame_loss_defect) |->
      $past(st_r.state) == ST_LOSS && st_r.state == ST_IN_FRAME)
    else $error("Frame loss cleared outside the loss-only state.");

  a_read_data_idle: assert property (
    !rd_i |=> rd_data_o == `RD_IDLE)
    else $error("Read data not idle outside a read answer.");

endmodule

// ### verification/frame_source.sv
`timescale 1ns/100ps
// ****************************************************************
// Line-side frame source: one strobe per go, after a short gap.
// ****************************************************************
module frame_source
  import frame_sync_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic go_i,
  input wire logic err_i,
  input wire logic [1:0] gap_i,
  output frame_obs_s frame_o
);
  logic busy_r;
  logic err_r;
  logic [1:0] cnt_r;
  // The error line toggles between frames so a stale value never helps.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
      err_r <= 1'b0;
      cnt_r <= 2'h0;
      frame_o <= '0;
    end else begin
      frame_o.strobe <= 1'b0;
      frame_o.err <= ~frame_o.err;
      if (go_i && !busy_r) begin
        busy_r <= 1'b1;
        err_r <= err_i;
        cnt_r <= gap_i;
      end else if (busy_r && cnt_r == 2'h0) begin
        frame_o.strobe <= 1'b1;
        frame_o.err <= err_r;
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// ### verification/rx_frame_sync_defect_monitor_test.sv
`timescale 1ns/100ps
`include "frame_sync_map.svh"
module rx_frame_sync_defect_monitor_test;
  import frame_sync_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic go = 1'b0;
  logic err = 1'b0;
  logic [1:0] gap = 2'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  frame_obs_s frame;
  logic [7:0] rd_data;
  logic irq_n;
  logic sev;
  logic loss;
  logic dut_irq_n;
  logic dut_sev;
  logic dut_loss;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$];

  frame_source SRC (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .go_i(go), .err_i(err), .gap_i(gap), .frame_o(frame));

  // A short persistence keeps the loss scenario to a few hundred cycles.
  frame_sync_monitor #(.PERSIST_CYCLES(200)) DUT (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .frame_i(frame),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rd_data), .irq_n_o(dut_irq_n),
    .severely_errored_frame_defect_o(dut_sev),
    .frame_loss_defect_o(dut_loss));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task report(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task chk_rd(input logic [7:0] g, input logic [7:0] e);
    report(g, e);
  endtask

  task chk_lvl(input logic g, input logic e);
    report({7'h00, g}, {7'h00, e});
  endtask

  task complete_run;
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Read data watcher.
  // ****************************************************************
  // Levels are copied on the falling edge, where they have settled, so
  // the stimulus process never races the edge that launches them.
  always @(negedge ref_clk_i) begin
    irq_n <= dut_irq_n;
    sev <= dut_sev;
    loss <= dut_loss;
  end

  always @(posedge ref_clk_i) begin
    rd_d <= rd;
  end

  always @(negedge ref_clk_i) begin
    if (rd_d) begin
      if (exp_q.size() > 0) begin
        chk_rd(rd_data, exp_q.pop_front());
      end else begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time,
                 rd_data, `RD_IDLE);
      end
    end else if (!sys_rst_i) begin
      chk_rd(rd_data, `RD_IDLE);
    end
  end

  // Strobes stay up so bus cycles can run back to back; idle drops them.
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge ref_clk_i);
  endtask

  task idle;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task send_frame(input logic e);
    int i;
    go <= 1'b1;
    err <= e;
    gap <= 2'($urandom % 4);
    @(posedge ref_clk_i);
    go <= 1'b0;
    for (i = 0; i < 10 && frame.strobe !== 1'b1; i++)
      @(posedge ref_clk_i);
    if (i == 10) begin
      miscompares++;
      complete_run();
    end
  endtask

  task frames(input int n, input logic e);
    repeat (n) send_frame(e);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    int k;
    int run;
    logic e;
    void'($urandom(13358));
    tick(8);
    sys_rst_i <= 1'b0;
    tick(1);
    bus(0, `DEFECT_STATUS_ADDR, 8'h00);
    bus(0, `INT_STATUS_ADDR, `INT_STATUS_RST);
    bus(0, `INT_MASK_ADDR, `INT_MASK_RST);
    bus(0, 16'h1100, 8'h00);
    bus(1, `DEFECT_STATUS_ADDR, 8'hFF);
    bus(0, `DEFECT_STATUS_ADDR, 8'h00);
    idle();
    chk_lvl(irq_n, 1'b1);
    run = 0;
    for (k = 0; k < 40; k++) begin
      e = ($urandom % 2) && run < 3;
      run = e ? run + 1 : 0;
      send_frame(e);
    end
    tick(1);
    chk_lvl(sev, 1'b0);
    frames(1, 1'b0);
    frames(3, 1'b1);
    tick(1);
    chk_lvl(sev, 1'b0);
    frames(1, 1'b1);
    tick(1);
    chk_lvl(sev, 1'b1);
    chk_lvl(irq_n, 1'b0);
    bus(0, `DEFECT_STATUS_ADDR, 8'h02);
    bus(0, `INT_STATUS_ADDR, 8'h02);
    bus(0, `INT_STATUS_ADDR, 8'h00);
    idle();
    chk_lvl(irq_n, 1'b1);
    frames(3, 1'b1);
    send_frame(1'b0);
    send_frame(1'b1);
    send_frame(1'b0);
    tick(1);
    chk_lvl(sev, 1'b1);
    send_frame(1'b0);
    tick(1);
    chk_lvl(sev, 1'b0);
    bus(0, `DEFECT_STATUS_ADDR, 8'h00);
    bus(0, `INT_STATUS_ADDR, 8'h02);
    idle();
    frames(4, 1'b1);
    bus(0, `INT_STATUS_ADDR, 8'h02);
    idle();
    tick(140);
    chk_lvl(loss, 1'b0);
    tick(70);
    chk_lvl(loss, 1'b1);
    bus(0, `DEFECT_STATUS_ADDR, 8'h06);
    idle();
    chk_lvl(irq_n, 1'b0);
    bus(1, `INT_MASK_ADDR, 8'h00);
    idle();
    tick(1);
    chk_lvl(irq_n, 1'b1);
    bus(1, `INT_MASK_ADDR, 8'h06);
    idle();
    tick(1);
    chk_lvl(irq_n, 1'b0);
    bus(1, `INT_STATUS_ADDR, 8'h04);
    bus(0, `INT_STATUS_ADDR, 8'h00);
    idle();
    chk_lvl(irq_n, 1'b1);
    frames(2, 1'b0);
    tick(1);
    chk_lvl(sev, 1'b0);
    chk_lvl(loss, 1'b1);
    frames(8, 1'b0);
    tick(1);
    chk_lvl(loss, 1'b0);
    bus(0, `DEFECT_STATUS_ADDR, 8'h00);
    bus(0, `INT_STATUS_ADDR, 8'h06);
    idle();
    tick(2);
    complete_run();
  end
endmodule
